// File: pkg/eic_regs.svh
// register offsets, field positions, reset values and timing counts for the pin front end
`ifndef EIC_REGS_SVH
`define EIC_REGS_SVH

// word byte addresses
`define EIC_ADDR_CTRL      4'h0
`define EIC_ADDR_STATUS    4'h4
`define EIC_ADDR_MASK      4'h8
`define EIC_ADDR_KEYPAD    4'hC
// address width of the slave
`define EIC_AW             4
// ctrl register fields
`define EIC_CTRL_EDGE1     0
`define EIC_CTRL_EDGE2     1
`define EIC_CTRL_TIMER_ZERO_GATE_SELECT     2
`define EIC_CTRL_TIMER_ONE_GATE_SELECT     3
`define EIC_CTRL_CNT0      4
`define EIC_CTRL_CNT1      5
`define EIC_CTRL_KP_EN     6
`define EIC_CTRL_IDLE      7
`define EIC_CTRL_PDOWN     8
`define EIC_CTRL_W         9
`define EIC_CTRL_RESET     9'h000
// keypad register: trigger polarity in bits 7:0, enables in bits 15:8
`define EIC_KP_POL_LSB     0
`define EIC_KP_EN_LSB      8
`define EIC_KP_RESET       16'h0000
// status bits
`define EIC_ST_EXT1        0
`define EIC_ST_EXT2        1
`define EIC_ST_KEYPAD      2
`define EIC_ST_W           3
`define EIC_ST_RESET       3'h0
// keypad hold time in oscillator periods and the derived clock count
`define EIC_KP_HOLD_PERIODS 24
`define EIC_CLK_NS          20
`define EIC_OSC_NS          20
`define EIC_KP_HOLD_CYCLES  ((`EIC_KP_HOLD_PERIODS * `EIC_OSC_NS + `EIC_CLK_NS - 1) / `EIC_CLK_NS)
`define EIC_KP_CNT_W        5
`define EIC_KP_CNT_RESET    5'h00
`define EIC_BYTE_RESET      8'h00
`define EIC_WORD_RESET      32'h00000000

`endif

// File: pkg/eic_pkg.sv
// types shared by the pin front end
package eic_pkg;
    `include "eic_regs.svh"

    // bus slave phase, one-hot
    typedef enum logic [1:0] {
        EIC_BUS_IDLE = 2'b01,
        EIC_BUS_DONE = 2'b10
    } eic_bus_type;

    // synchroniser state of one group of pins
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] sync;
        logic [7:0] prev;
    } eic_sync_type;
endpackage

// File: verilog/eic_sync.sv
// two-flop synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
module eic_sync (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // raw pins
    input  wire logic [7:0] pin_raw,
    // synchronised level and one cycle older copy
    output logic      [7:0] pin_sync,
    output logic      [7:0] pin_prev
);
    import eic_pkg::*;

    eic_sync_type state;       // registered state
    eic_sync_type next_state;  // next value

    // first flop feeds only the second; pins idle high after reset
    always_comb begin
        next_state      = state;
        next_state.meta = pin_raw;
        next_state.sync = state.meta;
        next_state.prev = state.sync;
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= {3{8'hFF}};
        end else begin
            state <= next_state;
        end
    end

    assign pin_sync = state.sync;
    assign pin_prev = state.prev;
endmodule

// File: verilog/eic_top.sv
// external interrupt, timer gate, counter input and keypad front end with Avalon-MM registers
`timescale 1ns/1ps
module eic_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // external pins
    input  wire logic        ext_irq_pin_first,
    input  wire logic        ext_irq_pin_second,
    input  wire logic        timer_zero_count_pin,
    input  wire logic        timer_one_count_pin,
    input  wire logic [7:0]  keypad_input_lines,
    // towards timers and cpu
    output logic             timer_zero_run,
    output logic             timer_one_run,
    output logic             timer_zero_count_pulse,
    output logic             timer_one_count_pulse,
    output logic             cpu_clock_stop,
    output logic             periph_clock_stop,
    output logic             wake_request,
    output logic             irq
);
    import eic_pkg::*;

    // whole module state
    typedef struct packed {
        eic_bus_type                 bus;
        logic [31:0]                 rdata;
        logic [`EIC_CTRL_W-1:0]      ctrl;
        logic [`EIC_ST_W-1:0]        status;
        logic [`EIC_ST_W-1:0]        mask;
        logic [15:0]                 keypad_control_register;
        logic [7:0]                  kp_source;
        logic [7:0][`EIC_KP_CNT_W-1:0] kp_count; // packed, so the whole state stays one packed struct
        logic                        t0_run;
        logic                        t1_run;
        logic                        t0_pulse;
        logic                        t1_pulse;
        logic                        cpu_stop;
        logic                        per_stop;
        logic                        wake;
        logic                        irq;
    } eic_state_type;

    eic_state_type state;       // registered state
    eic_state_type next_state;  // next value

    logic [7:0] misc_sync;      // synchronised single pins
    logic [7:0] misc_prev;      // one cycle older copy
    logic [7:0] kp_sync;        // synchronised keypad lines
    logic [7:0] kp_new;         // keypad lines reaching the hold time this cycle
    logic       kp_hit;         // enabled keypad event this cycle, seen by the checks too
    logic [7:0] misc_raw;       // single pins gathered
    logic       ext1_lvl;       // first pin, synchronised
    logic       ext2_lvl;       // second pin, synchronised
    logic       ext1_fall;      // first pin falling edge
    logic       ext2_fall;      // second pin falling edge
    logic       t0_fall;        // timer zero pin falling edge
    logic       t1_fall;        // timer one pin falling edge

    // falling edge from a synchronised level and its older copy
    function automatic logic fell(input logic now, input logic old);
        return old & ~now;
    endfunction

    assign misc_raw = {4'hF, timer_one_count_pin, timer_zero_count_pin, ext_irq_pin_second, ext_irq_pin_first};

    // pins synchronised before any edge, level or hold logic
    eic_sync u_sync_misc (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_raw  (misc_raw),
        .pin_sync (misc_sync),
        .pin_prev (misc_prev)
    );

    eic_sync u_sync_kp (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_raw  (keypad_input_lines),
        .pin_sync (kp_sync),
        .pin_prev ()
    );

    // edge and level views of the single pins
    assign ext1_lvl  = misc_sync[0];
    assign ext2_lvl  = misc_sync[1];
    assign ext1_fall = fell(misc_sync[0], misc_prev[0]);
    assign ext2_fall = fell(misc_sync[1], misc_prev[1]);
    assign t0_fall   = fell(misc_sync[2], misc_prev[2]);
    assign t1_fall   = fell(misc_sync[3], misc_prev[3]);

    // next state: bus slave, flags, gates, counters and keypad timers
    always_comb begin
        logic [`EIC_ST_W-1:0] set_ev;
        logic [`EIC_ST_W-1:0] clr_ev;
        logic                 kp_active;
        set_ev    = '0;
        clr_ev    = '0;
        kp_hit    = 1'b0;
        kp_new    = '0;
        kp_active = 1'b0;
        next_state = state;

        // external interrupt sources, edge or level by select bit
        if (state.ctrl[`EIC_CTRL_EDGE1]) begin
            set_ev[`EIC_ST_EXT1] = ext1_fall;
        end else begin
            set_ev[`EIC_ST_EXT1] = ~ext1_lvl;
        end
        if (state.ctrl[`EIC_CTRL_EDGE2]) begin
            set_ev[`EIC_ST_EXT2] = ext2_fall;
        end else begin
            set_ev[`EIC_ST_EXT2] = ~ext2_lvl;
        end

        // keypad hold counters; an enabled line at its trigger level counts up, else restarts
        for (int i = 0; i < 8; i++) begin
            kp_active = state.keypad_control_register[`EIC_KP_EN_LSB + i]
                        & (kp_sync[i] == state.keypad_control_register[`EIC_KP_POL_LSB + i]);
            if (!kp_active) begin
                next_state.kp_count[i] = `EIC_KP_CNT_RESET;
            end else if (state.kp_count[i] != `EIC_KP_CNT_W'(`EIC_KP_HOLD_CYCLES)) begin
                next_state.kp_count[i] = state.kp_count[i] + `EIC_KP_CNT_W'(1);
                // fire once, on reaching the hold time
                if (state.kp_count[i] == `EIC_KP_CNT_W'(`EIC_KP_HOLD_CYCLES - 1)) begin
                    kp_new[i] = 1'b1;
                end
            end
        end
        kp_hit = state.ctrl[`EIC_CTRL_KP_EN] & (|kp_new);
        set_ev[`EIC_ST_KEYPAD] = kp_hit;
        // source lines accumulate until software writes the keypad register
        next_state.kp_source = state.kp_source | (kp_hit ? kp_new : 8'h00);

        // gate: pin high lets timer run; without gate it runs freely
        next_state.t0_run = ~state.ctrl[`EIC_CTRL_TIMER_ZERO_GATE_SELECT] | ext1_lvl;
        next_state.t1_run = ~state.ctrl[`EIC_CTRL_TIMER_ONE_GATE_SELECT] | ext2_lvl;
        // count pulses only in counter mode
        next_state.t0_pulse = state.ctrl[`EIC_CTRL_CNT0] & t0_fall;
        next_state.t1_pulse = state.ctrl[`EIC_CTRL_CNT1] & t1_fall;

        // bus slave: one wait cycle, answer on the second
        next_state.bus = EIC_BUS_IDLE;
        unique case (state.bus)
            EIC_BUS_IDLE: begin
                if (avs_read | avs_write) begin
                    next_state.bus = EIC_BUS_DONE;
                    next_state.rdata = `EIC_WORD_RESET;
                    unique case (avs_address)
                        `EIC_ADDR_CTRL:   next_state.rdata[`EIC_CTRL_W-1:0] = state.ctrl;
                        `EIC_ADDR_STATUS: next_state.rdata[`EIC_ST_W-1:0] = state.status;
                        `EIC_ADDR_MASK:   next_state.rdata[`EIC_ST_W-1:0] = state.mask;
                        `EIC_ADDR_KEYPAD: next_state.rdata = {8'h00, state.kp_source, state.keypad_control_register};
                        default:          next_state.rdata = `EIC_WORD_RESET;
                    endcase
                end
            end
            EIC_BUS_DONE: begin
                if (avs_write) begin
                    unique case (avs_address)
                        `EIC_ADDR_CTRL:   next_state.ctrl = avs_writedata[`EIC_CTRL_W-1:0];
                        `EIC_ADDR_STATUS: clr_ev = avs_writedata[`EIC_ST_W-1:0];
                        `EIC_ADDR_MASK:   next_state.mask = avs_writedata[`EIC_ST_W-1:0];
                        `EIC_ADDR_KEYPAD: begin
                            next_state.keypad_control_register = avs_writedata[15:0];
                            // clearing the record; a same-cycle hit survives
                            next_state.kp_source = kp_hit ? kp_new : `EIC_BYTE_RESET;
                        end
                        default: ;
                    endcase
                end
            end
        endcase

        // sticky flags, set wins over write-one-to-clear
        next_state.status = (state.status & ~clr_ev) | set_ev;

        // idle stops cpu only; power down also freezes peripherals
        next_state.cpu_stop = state.ctrl[`EIC_CTRL_IDLE] | state.ctrl[`EIC_CTRL_PDOWN];
        next_state.per_stop = state.ctrl[`EIC_CTRL_PDOWN];
        // unmasked pin events still wake the device even with clocks frozen
        next_state.wake = |(set_ev & state.mask);
        if (next_state.wake) begin
            next_state.ctrl[`EIC_CTRL_IDLE]  = 1'b0;
            next_state.ctrl[`EIC_CTRL_PDOWN] = 1'b0;
        end
        next_state.irq = |(next_state.status & next_state.mask);
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state.bus    <= EIC_BUS_IDLE;
            state.rdata  <= `EIC_WORD_RESET;
            state.ctrl   <= `EIC_CTRL_RESET;
            state.status <= `EIC_ST_RESET;
            state.mask   <= `EIC_ST_RESET;
            state.keypad_control_register <= `EIC_KP_RESET;
            state.kp_source <= `EIC_BYTE_RESET;
            for (int i = 0; i < 8; i++) begin
                state.kp_count[i] <= `EIC_KP_CNT_RESET;
            end
            state.t0_run   <= 1'b1;
            state.t1_run   <= 1'b1;
            state.t0_pulse <= 1'b0;
            state.t1_pulse <= 1'b0;
            state.cpu_stop <= 1'b0;
            state.per_stop <= 1'b0;
            state.wake     <= 1'b0;
            state.irq      <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign avs_readdata           = state.rdata;
    // the idle bit of the one-hot phase is the wait flag itself, no gate after the flop
    assign avs_waitrequest        = state.bus[0];
    assign timer_zero_run         = state.t0_run;
    assign timer_one_run          = state.t1_run;
    assign timer_zero_count_pulse = state.t0_pulse;
    assign timer_one_count_pulse  = state.t1_pulse;
    assign cpu_clock_stop         = state.cpu_stop;
    assign periph_clock_stop      = state.per_stop;
    assign wake_request           = state.wake;
    assign irq                    = state.irq;

    // level mode keeps the first flag set while the pin stays low
    chk_level_first_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (!state.ctrl[`EIC_CTRL_EDGE1] && !ext1_lvl) |=> state.status[`EIC_ST_EXT1])
        else $error("first flag not set by low level");

    // edge mode sets the second flag one cycle after a fall
    chk_edge_second_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (state.ctrl[`EIC_CTRL_EDGE2] && ext2_fall) |=> state.status[`EIC_ST_EXT2])
        else $error("second flag missed falling edge");

    // edge mode without a fall and without a prior flag leaves it clear
    chk_edge_first_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (state.ctrl[`EIC_CTRL_EDGE1] && !ext1_fall && !state.status[`EIC_ST_EXT1]) |=> !state.status[`EIC_ST_EXT1])
        else $error("first flag set without edge");

    // gated timer zero follows the first pin
    chk_gate_zero_run: assert property (@(posedge clk) disable iff (!rst_n)
        state.ctrl[`EIC_CTRL_TIMER_ZERO_GATE_SELECT] |=> (timer_zero_run == $past(ext1_lvl)))
        else $error("timer zero gate wrong");

    // gated timer one follows the second pin
    chk_gate_one_run: assert property (@(posedge clk) disable iff (!rst_n)
        state.ctrl[`EIC_CTRL_TIMER_ONE_GATE_SELECT] |=> (timer_one_run == $past(ext2_lvl)))
        else $error("timer one gate wrong");

    // timer zero pulses only on falls in counter mode; timer one pulses on every fall in counter mode
    chk_count_zero_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        timer_zero_count_pulse |-> $past(t0_fall) && $past(state.ctrl[`EIC_CTRL_CNT0]))
        else $error("timer zero pulse without cause");

    chk_count_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (state.ctrl[`EIC_CTRL_CNT1] && t1_fall) |=> timer_one_count_pulse)
        else $error("timer one pulse missed");

    // keypad flag rises only after some enabled line reached its hold time
    chk_keypad_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state.status[`EIC_ST_KEYPAD]) |-> $past(kp_new != 8'h00))
        else $error("keypad flag without hold");

    // keypad hit is recorded in the source bits
    chk_keypad_source: assert property (@(posedge clk) disable iff (!rst_n)
        kp_hit |=> ((state.kp_source & $past(kp_new)) == $past(kp_new)))
        else $error("keypad source not recorded");

    // power down always stops the cpu too
    chk_pdown_stop: assert property (@(posedge clk) disable iff (!rst_n)
        periph_clock_stop |-> cpu_clock_stop)
        else $error("power down without cpu stop");
endmodule

// File: verification/eic_pins.sv
// pin-side partner: drives the external pins the way a board would
`timescale 1ns/1ps
module eic_pins (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // levels asked for by the bench
    input  wire logic [1:0] want_ext,
    input  wire logic [1:0] want_cnt,
    input  wire logic [7:0] want_kp,
    // pins towards the device
    output logic      [1:0] ext_pin,
    output logic      [1:0] cnt_pin,
    output logic      [7:0] kp_pin
);
    // pins move just after an edge; the reset branch loads them high while the board sits in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_pin <= 2'h3;
            cnt_pin <= 2'h3;
            kp_pin  <= 8'hFF;
        end else begin
            ext_pin <= want_ext;
            cnt_pin <= want_cnt;
            kp_pin  <= want_kp;
        end
    end
endmodule

// File: verification/eic_top_tb.sv
// self-checking bench for the pin front end
`timescale 1ns/1ps
`include "eic_regs.svh"
module eic_top_tb;
    import eic_pkg::*;
    // clock, reset and bus
    logic        clk           = 1'b0;
    logic        rst_n         = 1'b0;
    logic [3:0]  avs_address   = 4'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    // pin requests and the pins themselves
    logic [1:0]  want_ext      = 2'h3;
    logic [1:0]  want_cnt      = 2'h3;
    logic [7:0]  want_kp       = 8'hFF;
    logic [1:0]  ext_pin;
    logic [1:0]  cnt_pin;
    logic [7:0]  kp_pin;
    // outputs towards timers and cpu
    logic [1:0]  run;
    logic [1:0]  pulse;
    logic        cpu_stop;
    logic        periph_stop;
    logic        wake;
    logic        irq;
    // bookkeeping
    int          error_cnt     = 0;
    int          n_checks      = 0;
    int          pulse_cnt [2] = '{0, 0};
    int          wake_cnt      = 0;
    logic [31:0] rd;
    logic [3:0]  addrs [5]     = '{`EIC_ADDR_CTRL, `EIC_ADDR_STATUS, `EIC_ADDR_MASK, `EIC_ADDR_KEYPAD, 4'h2};

    eic_pins pins (.clk(clk), .rst_n(rst_n), .want_ext(want_ext), .want_cnt(want_cnt), .want_kp(want_kp),
        .ext_pin(ext_pin), .cnt_pin(cnt_pin), .kp_pin(kp_pin));
    eic_top DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_pin_first(ext_pin[0]), .ext_irq_pin_second(ext_pin[1]),
        .timer_zero_count_pin(cnt_pin[0]), .timer_one_count_pin(cnt_pin[1]), .keypad_input_lines(kp_pin),
        .timer_zero_run(run[0]), .timer_one_run(run[1]), .timer_zero_count_pulse(pulse[0]),
        .timer_one_count_pulse(pulse[1]), .cpu_clock_stop(cpu_stop), .periph_clock_stop(periph_stop),
        .wake_request(wake), .irq(irq));

    // 50 MHz clock
    always #10 clk = ~clk;

    // count one-cycle pulses; a pulse standing two cycles would count twice
    always @(posedge clk) begin
        if (pulse[0] === 1'b1) pulse_cnt[0]++;
        if (pulse[1] === 1'b1) pulse_cnt[1]++;
        if (wake === 1'b1) wake_cnt++;
    end

    // expectations
    function automatic logic exp_run(input logic gate, input logic pin);
        return !gate | pin;
    endfunction
    function automatic logic [31:0] exp_kp(input int k, input int p, input logic src);
        return (32'h1 << (k + 8)) | (p != 0 ? 32'h000000FF : 32'h0) | (src ? (32'h1 << (k + 16)) : 32'h0);
    endfunction

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            close_out();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk32(rd, exp, "read");
    endtask
    // pin levels; sync plus registering takes about four cycles, so settle waits twice that
    task automatic drive(input logic [1:0] e, input logic [1:0] c, input logic [7:0] kp);
        @(posedge clk);
        want_ext <= e;
        want_cnt <= c;
        want_kp  <= kp;
    endtask
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    // main sequence
    initial begin
        int seed;
        int n;
        int base;
        int k;
        int p;
        logic [7:0] idle;
        seed = $urandom(32'h14E1);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, and the unmapped hole swallows a write
        wr(4'h2, 32'hFFFFFFFF);
        foreach (addrs[j]) rdchk(addrs[j], 32'h0);
        chk1(run[0] & run[1], 1'b1, "run after reset");
        // external flags: edge, level and masked, for both pins
        for (int i = 0; i < 2; i++) begin
            wr(`EIC_ADDR_MASK, 32'h1 << i);
            wr(`EIC_ADDR_CTRL, 32'h1 << i);
            drive(~(2'h1 << i), 2'h3, 8'hFF);
            settle();
            chk1(irq, 1'b1, "edge irq");
            wr(`EIC_ADDR_STATUS, 32'h1 << i);
            settle();
            rdchk(`EIC_ADDR_STATUS, 32'h0);
            drive(2'h3, 2'h3, 8'hFF);
            wr(`EIC_ADDR_CTRL, 32'h0);
            drive(~(2'h1 << i), 2'h3, 8'hFF);
            settle();
            wr(`EIC_ADDR_STATUS, 32'h1 << i);
            rdchk(`EIC_ADDR_STATUS, 32'h1 << i);
            drive(2'h3, 2'h3, 8'hFF);
            settle();
            wr(`EIC_ADDR_STATUS, 32'h1 << i);
            rdchk(`EIC_ADDR_STATUS, 32'h0);
            wr(`EIC_ADDR_MASK, 32'h0);
            drive(~(2'h1 << i), 2'h3, 8'hFF);
            settle();
            chk1(irq, 1'b0, "masked irq");
            drive(2'h3, 2'h3, 8'hFF);
            settle();
            wr(`EIC_ADDR_STATUS, 32'h7);
        end
        // gate selects against both pin levels
        for (int g = 0; g < 4; g++) begin
            wr(`EIC_ADDR_CTRL, 32'(g) << `EIC_CTRL_TIMER_ZERO_GATE_SELECT);
            for (int pv = 0; pv < 2; pv++) begin
                drive({2{pv[0]}}, 2'h3, 8'hFF);
                settle();
                chk1(run[0], exp_run(g[0], pv[0]), "run zero");
                chk1(run[1], exp_run(g[1], pv[0]), "run one");
            end
        end
        wr(`EIC_ADDR_STATUS, 32'h7);
        // counter inputs, random burst length, counter mode on and off
        for (int t = 0; t < 4; t++) begin
            wr(`EIC_ADDR_CTRL, 32'(t[1]) << (`EIC_CTRL_CNT0 + t[0]));
            n = 1 + $urandom % 6;
            base = pulse_cnt[t[0]];
            repeat (n) begin
                drive(2'h3, ~(2'h1 << t[0]), 8'hFF);
                repeat (3) @(posedge clk);
                drive(2'h3, 2'h3, 8'hFF);
                repeat (3) @(posedge clk);
            end
            settle();
            chk32(pulse_cnt[t[0]] - base, t[1] ? n : 0, "pulse count");
        end
        // keypad: short press ignored, long press reported, source cleared by a write
        wr(`EIC_ADDR_MASK, 32'h4);
        repeat (3) begin
            k = $urandom % 8;
            p = $urandom % 2;
            idle = (p != 0) ? 8'h00 : 8'hFF;
            // park the lines at the new idle level before any line is enabled
            wr(`EIC_ADDR_KEYPAD, 32'h0);
            drive(2'h3, 2'h3, idle);
            settle();
            wr(`EIC_ADDR_CTRL, 32'h1 << `EIC_CTRL_KP_EN);
            wr(`EIC_ADDR_KEYPAD, exp_kp(k, p, 1'b0));
            drive(2'h3, 2'h3, idle ^ (8'h01 << k));
            repeat (20) @(posedge clk);
            drive(2'h3, 2'h3, idle);
            settle();
            rdchk(`EIC_ADDR_STATUS, 32'h0);
            drive(2'h3, 2'h3, idle ^ (8'h01 << k));
            repeat (30) @(posedge clk);
            drive(2'h3, 2'h3, idle);
            settle();
            chk1(irq, 1'b1, "keypad irq");
            rdchk(`EIC_ADDR_STATUS, 32'h4);
            rdchk(`EIC_ADDR_KEYPAD, exp_kp(k, p, 1'b1));
            wr(`EIC_ADDR_KEYPAD, exp_kp(k, p, 1'b0));
            rdchk(`EIC_ADDR_KEYPAD, exp_kp(k, p, 1'b0));
            wr(`EIC_ADDR_STATUS, 32'h4);
            wr(`EIC_ADDR_CTRL, 32'h0);
            drive(2'h3, 2'h3, idle ^ (8'h01 << k));
            repeat (30) @(posedge clk);
            drive(2'h3, 2'h3, idle);
            settle();
            chk1(irq, 1'b0, "keypad disabled");
            wr(`EIC_ADDR_STATUS, 32'h4);
        end
        // idle then power-down, each woken by an external pin
        for (int m = 0; m < 2; m++) begin
            wr(`EIC_ADDR_MASK, 32'h1 << m);
            wr(`EIC_ADDR_CTRL, (32'h1 << (`EIC_CTRL_IDLE + m)) | (32'h1 << m));
            settle();
            chk1(m ? periph_stop : cpu_stop, 1'b1, "stop raised");
            chk1(m ? cpu_stop : periph_stop, m[0], "other stop");
            base = wake_cnt;
            drive(~(2'h1 << m), 2'h3, 8'hFF);
            settle();
            chk1(cpu_stop | periph_stop, 1'b0, "woken");
            chk32(wake_cnt - base, 32'h1, "wake pulses");
            rdchk(`EIC_ADDR_STATUS, 32'h1 << m);
            rdchk(`EIC_ADDR_CTRL, 32'h1 << m);
            drive(2'h3, 2'h3, 8'hFF);
            settle();
            wr(`EIC_ADDR_STATUS, 32'h7);
        end
        close_out();
    end
endmodule
